// ==== flash_read_defs.svh ====
// opcodes, dummy defaults and phase lengths of the dtr read sequencer
// assumes inclusion by its bare name from the sequencer only
`ifndef FLASH_READ_DEFS_SVH
`define FLASH_READ_DEFS_SVH

// opcodes
`define OP_INFO_ROW_READ 8'h68
`define OP_DTR_SINGLE    8'h0D
`define OP_DTR_DUAL      8'hBD

// upper mode nibble that keeps command skip alive
`define SKIP_NIBBLE      4'hA

// default dummy clocks per read kind
`define DUMMY_INFO_SPI   4'h8
`define DUMMY_INFO_QPI   4'h6
`define DUMMY_DTR_SINGLE 4'h8
`define DUMMY_DTR_QUAD   4'h6
`define DUMMY_DTR_DUAL   4'h4

// phase lengths in bits
`define CMD_BITS         5'h08
`define ADDR_BITS        5'h18

`endif

// ==== flash_read_pkg.sv ====
// types shared by the dtr read sequencer and its surroundings
// assumes nothing beyond a systemverilog compiler
`default_nettype none

package flash_read_pkg;

  typedef enum logic [2:0] {
    ST_CMD,
    ST_ADDR,
    ST_DUMMY,
    ST_DATA,
    ST_IGNORE
  } seq_state_type;

  typedef enum logic [1:0] {
    RK_INFO,
    RK_SINGLE,
    RK_DUAL,
    RK_QUAD
  } read_kind_type;

  typedef struct packed {
    logic       qpi;
    logic       busy;
    logic [3:0] dummy;
  } link_cfg_type;

  typedef struct packed {
    logic        info;
    logic [23:0] addr;
  } mem_req_type;

endpackage

`default_nettype wire

// ==== sync_2ff.sv ====
// two flip-flop level synchroniser of a parameter width
// assumes the input is a quasi-static level from another clock domain
`timescale 1ns/100ps
`default_nettype none

module sync_2ff #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // level in and out
  input  wire logic [WIDTH-1:0] d,
  output var  logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;

  // the first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= '0;
      q      <= '0;
    end
    else
    begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

`default_nettype wire

// ==== event_cross.sv ====
// carries single-cycle events between two clocks through a toggle
// assumes events at the source are spaced by more than three dest cycles
`timescale 1ns/100ps
`default_nettype none

module event_cross (
  // source side
  input  wire logic src_clk,
  input  wire logic src_rst_n,
  input  wire logic src_pulse,
  // destination side
  input  wire logic dst_clk,
  input  wire logic dst_rst_n,
  output var  logic dst_pulse
);

  logic toggle_q;
  logic meta_q;
  logic sync_q;
  logic hist_q;

  always_ff @(posedge src_clk or negedge src_rst_n)
  begin
    if (!src_rst_n)
      toggle_q <= 1'b0;
    else
      toggle_q <= toggle_q ^ src_pulse;
  end

  // a toggle survives a source clock that stops right after the event
  always_ff @(posedge dst_clk or negedge dst_rst_n)
  begin
    if (!dst_rst_n)
    begin
      meta_q    <= 1'b0;
      sync_q    <= 1'b0;
      hist_q    <= 1'b0;
      dst_pulse <= 1'b0;
    end
    else
    begin
      meta_q    <= toggle_q;
      sync_q    <= meta_q;
      hist_q    <= sync_q;
      dst_pulse <= sync_q ^ hist_q;
    end
  end

endmodule

`default_nettype wire

// ==== dtr_read_sequencer.sv ====
// read command sequencer of a serial flash: info row, dtr single,
// dtr dual with command skip, and the four-line dtr read.
// assumes the host owns sck and cs_n, the array answers mem_rdata
// combinationally for mem_req, and config inputs change between frames.
//
// What this block does
// - info row read is 68h, three address bytes, 8 dummy clocks, rising.
// - after dummies, info row bytes go out on the output line, falling.
// - info row address steps by one per byte; past 256 is garbage.
// - info row read is ignored while a write is in progress.
// - raising chip select ends an info row read and stops driving.
// - in four-line mode info row read follows the four-line fast read.
// - single-line dtr read 0Dh, address two bits a clock, 8 dummies.
// - single-line dtr moves one bit per rising and one per falling edge.
// - dtr reads step the address per byte and wrap to zero at the top.
// - host may end a dtr read any time by raising chip select.
// - single-line dtr read is rejected during a write cycle.
// - four-line 0Dh: two-clock opcode, 8 bits a clock, 6 dummies.
// - the four-line 0Dh read never enters command skip.
// - four-line 0Dh read is rejected during a write cycle.
// - dual dtr read BDh, address four bits a clock, 4 dummy clocks.
// - dual dtr moves two bits on each edge over two lines.
// - mode nibble A enters command skip; other values leave it.
// - dual dtr read is rejected during a write cycle.
// - info rows start at middle bytes 00h,10h,20h,30h, upper byte 00h.
`timescale 1ns/100ps
`default_nettype none

`include "flash_read_defs.svh"

module dtr_read_sequencer
  import flash_read_pkg::*;
(
  // device clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // serial link
  input  wire logic        sck,
  input  wire logic        cs_n,
  input  wire logic [3:0]  io_in,
  output var  logic [3:0]  io_out,
  output var  logic [3:0]  io_oe,
  // array read port, link clock
  output var  mem_req_type mem_req,
  input  wire logic [7:0]  mem_rdata,
  // device state, clk domain
  input  wire logic        write_in_progress_flag,
  input  wire logic        qpi_mode_en,
  input  wire logic [3:0]  dummy_cfg,
  // status, clk domain
  output var  logic        read_active,
  output var  logic        command_skip_mode,
  output var  logic        read_rejected
);

  // ************************************************************
  // crossings
  // ************************************************************
  link_cfg_type  cfg_in;
  link_cfg_type  cfg;
  logic [1:0]    status_q;
  logic          sck_n;
  logic          frame_rst_n;
  logic          reject;
  logic          skip_q;
  logic [3:0]    oe_q;

  assign cfg_in      = {qpi_mode_en, write_in_progress_flag, dummy_cfg};
  assign sck_n       = ~sck;
  // raising chip select clears the frame logic at once
  assign frame_rst_n = rstn & ~cs_n;

  // config only moves while sck runs, so it must settle before a frame
  sync_2ff #(
    .WIDTH (6)
  ) u_cfg_sync (
    .clk   (sck),
    .rst_n (rstn),
    .d     (cfg_in),
    .q     (cfg)
  );

  sync_2ff #(
    .WIDTH (2)
  ) u_status_sync (
    .clk   (clk),
    .rst_n (rstn),
    .d     ({skip_q, oe_q[1]}),
    .q     (status_q)
  );

  event_cross u_reject_cross (
    .src_clk   (sck_n),
    .src_rst_n (rstn),
    .src_pulse (reject),
    .dst_clk   (clk),
    .dst_rst_n (rstn),
    .dst_pulse (read_rejected)
  );

  assign command_skip_mode = status_q[1];
  assign read_active       = status_q[0];

  // ************************************************************
  // phase decode
  // ************************************************************
  seq_state_type state_q;
  seq_state_type state_d;
  read_kind_type kind_q;
  read_kind_type kind_eff;
  read_kind_type cmd_kind;
  logic [3:0]    rise_q;
  logic [23:0]   sh_q;
  logic [23:0]   sh_next;
  logic [23:0]   addr_q;
  logic [4:0]    bitcnt_q;
  logic [4:0]    cnt_sum;
  logic [3:0]    dcnt_q;
  logic [3:0]    dcnt_next;
  logic [3:0]    dummy_sel;
  logic [2:0]    obit_q;
  logic [7:0]    byte_q;
  logic [3:0]    out_a_q;
  logic [3:0]    out_b_q;
  logic          info_q;
  logic          skip_start;
  logic          in_cmd;
  logic          in_addr;
  logic          ddr;
  logic [2:0]    lanes;
  logic [3:0]    bpc;
  logic [3:0]    lmask;
  logic [7:0]    in_word;
  logic          cmd_done;
  logic          cmd_valid;
  logic          addr_done;
  logic          dummy_last;
  logic          emit;
  logic          mode_clock;

  function automatic logic [2:0] lanes_of(input read_kind_type k,
                                          input logic qpi);
    case (k)
      RK_INFO:   lanes_of = qpi ? 3'h4 : 3'h1;
      RK_DUAL:   lanes_of = 3'h2;
      RK_QUAD:   lanes_of = 3'h4;
      default:   lanes_of = 3'h1;
    endcase
  endfunction

  // a kept command skip turns the opcode slot into the address phase
  assign skip_start = (state_q == ST_CMD) && skip_q;
  assign in_cmd     = (state_q == ST_CMD) && !skip_q;
  assign in_addr    = (state_q == ST_ADDR) || skip_start;
  assign kind_eff   = skip_start ? RK_DUAL : kind_q;

  // opcode: one line, or four in four-line mode; dtr on both edges
  assign lanes = in_cmd ? (cfg.qpi ? 3'h4 : 3'h1)
                        : lanes_of(kind_eff, cfg.qpi);
  assign ddr   = !in_cmd && (kind_eff != RK_INFO);
  assign bpc   = {1'b0, lanes} << ddr;
  assign lmask = 4'((5'h01 << lanes) - 5'h01);

  // rising-edge bits come first, falling-edge bits follow
  assign in_word = ddr ? (({4'h0, rise_q & lmask} << lanes)
                          | {4'h0, io_in & lmask})
                       : {4'h0, rise_q & lmask};
  assign sh_next = (sh_q << bpc) | {16'h0000, in_word};
  assign cnt_sum = bitcnt_q + {1'b0, bpc};

  assign cmd_done  = in_cmd && (cnt_sum == `CMD_BITS);
  assign addr_done = in_addr && (cnt_sum == `ADDR_BITS);

  assign cmd_kind  = (sh_next[7:0] == `OP_INFO_ROW_READ) ? RK_INFO
                   : (sh_next[7:0] == `OP_DTR_DUAL)      ? RK_DUAL
                   : cfg.qpi                              ? RK_QUAD
                   :                                        RK_SINGLE;
  // the dual read exists only on the single-line command set
  assign cmd_valid = (sh_next[7:0] == `OP_INFO_ROW_READ)
                   || (sh_next[7:0] == `OP_DTR_SINGLE)
                   || ((sh_next[7:0] == `OP_DTR_DUAL) && !cfg.qpi);

  // a write in progress refuses every read kind here
  assign reject = cfg.busy && ((cmd_done && cmd_valid)
                  || (skip_start && addr_done));

  assign dummy_sel = (cfg.dummy != 4'h0) ? cfg.dummy
                   : (kind_q == RK_INFO)   ? (cfg.qpi ? `DUMMY_INFO_QPI
                                                      : `DUMMY_INFO_SPI)
                   : (kind_q == RK_SINGLE) ? `DUMMY_DTR_SINGLE
                   : (kind_q == RK_DUAL)   ? `DUMMY_DTR_DUAL
                   :                         `DUMMY_DTR_QUAD;
  assign dcnt_next  = dcnt_q + 4'h1;
  assign dummy_last = (state_q == ST_DUMMY) && (dcnt_next == dummy_sel);
  assign emit       = dummy_last || (state_q == ST_DATA);
  // the mode byte leads the dummies; only its upper nibble is judged,
  // so a floated low nibble does no harm
  assign mode_clock = (state_q == ST_DUMMY) && (dcnt_q == 4'h0)
                      && (kind_q == RK_DUAL);

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_CMD:
        if (skip_q)
        begin
          if (addr_done)
            state_d = cfg.busy ? ST_IGNORE : ST_DUMMY;
        end
        else if (cmd_done)
          state_d = (!cmd_valid || cfg.busy) ? ST_IGNORE : ST_ADDR;
      ST_ADDR:
        if (addr_done)
          state_d = ST_DUMMY;
      ST_DUMMY:
        if (dummy_last)
          state_d = ST_DATA;
      ST_DATA:   state_d = ST_DATA;
      ST_IGNORE: state_d = ST_IGNORE;
      default:   state_d = ST_IGNORE;
    endcase
  end

  // ************************************************************
  // input sampling and sequencing
  // ************************************************************
  // every input bit is taken on a rising edge, dtr partners on falling
  always_ff @(posedge sck or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
      rise_q <= 4'h0;
    else
      rise_q <= io_in;
  end

  always_ff @(posedge sck_n or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      state_q  <= ST_CMD;
      bitcnt_q <= 5'h00;
      sh_q     <= 24'h000000;
      dcnt_q   <= 4'h0;
    end
    else
    begin
      state_q  <= state_d;
      bitcnt_q <= cmd_done ? 5'h00 : cnt_sum;
      sh_q     <= (in_cmd || in_addr) ? sh_next : sh_q;
      dcnt_q   <= (state_q == ST_DUMMY) ? dcnt_next : 4'h0;
    end
  end

  always_ff @(posedge sck_n or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      kind_q <= RK_INFO;
      info_q <= 1'b0;
    end
    else if (skip_start && addr_done)
    begin
      kind_q <= RK_DUAL;
      info_q <= 1'b0;
    end
    else if (cmd_done)
    begin
      kind_q <= cmd_kind;
      info_q <= (cmd_kind == RK_INFO);
    end
  end

  // command skip outlives the frame; only a dual read's mode nibble moves it
  always_ff @(posedge sck_n or negedge rstn)
  begin
    if (!rstn)
      skip_q <= 1'b0;
    else if (mode_clock)
      skip_q <= (in_word[3:0] == `SKIP_NIBBLE);
  end

  // ************************************************************
  // address counter and data out
  // ************************************************************
  logic [7:0] src;
  logic [7:0] src_next;
  logic [3:0] slot_a;
  logic [3:0] slot_b;
  logic [3:0] line_a;
  logic [3:0] line_b;
  logic [3:0] oe_val;

  // a new byte is fetched whenever the previous one is used up
  assign src      = (obit_q == 3'h0) ? mem_rdata : byte_q;
  assign src_next = src << lanes;
  assign slot_a   = 4'(src >> (4'h8 - {1'b0, lanes}));
  assign slot_b   = ddr ? 4'(src_next >> (4'h8 - {1'b0, lanes}))
                        : slot_a;
  // a single line answers on line 1, wider reads from line 0 up
  assign line_a   = (lanes == 3'h1) ? {2'b00, slot_a[0], 1'b0} : slot_a;
  assign line_b   = (lanes == 3'h1) ? {2'b00, slot_b[0], 1'b0} : slot_b;
  assign oe_val   = (lanes == 3'h1) ? 4'h2 : lmask;

  always_ff @(posedge sck_n or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      addr_q  <= 24'h000000;
      obit_q  <= 3'h0;
      byte_q  <= 8'h00;
      out_a_q <= 4'h0;
      out_b_q <= 4'h0;
      oe_q    <= 4'h0;
    end
    else if (addr_done)
      addr_q <= sh_next;
    else if (emit)
    begin
      // 24-bit count wraps to zero past the top of the array
      if (obit_q == 3'h0)
        addr_q <= addr_q + 24'h000001;
      obit_q  <= obit_q + bpc[2:0];
      byte_q  <= src << bpc;
      out_a_q <= line_a;
      out_b_q <= line_b;
      oe_q    <= oe_val;
    end
  end

  assign mem_req = {info_q, addr_q};

  // low half of sck shows the rising-edge slot, high half the falling
  assign io_out = sck ? out_b_q : out_a_q;
  assign io_oe  = oe_q;

endmodule

`default_nettype wire

// ==== dtr_read_sequencer_chk.sv ====
// concurrent checks on the ports of the dtr read sequencer
// assumes binding to dtr_read_sequencer, rstn resets both domains
`timescale 1ns/100ps
`default_nettype none

module dtr_read_sequencer_chk
  import flash_read_pkg::*;
(
  // clocks and reset
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        sck,
  // link
  input wire logic        cs_n,
  input wire logic [3:0]  io_oe,
  input wire mem_req_type mem_req,
  // state and status
  input wire logic        write_in_progress_flag,
  input wire logic        qpi_mode_en,
  input wire logic        read_active,
  input wire logic        command_skip_mode,
  input wire logic        read_rejected
);
  sequence s_pulse;
    read_rejected ##1 !read_rejected;
  endsequence
  property p_oe_cs;
    @(posedge clk) disable iff (!rstn) cs_n |-> io_oe == 4'h0;
  endproperty
  a_oe_cs: assert property (p_oe_cs)
    else $error("lines driven while deselected");
  property p_lanes;
    @(negedge sck) disable iff (!rstn)
      io_oe != 4'h0 |-> io_oe inside {4'h2, 4'h3, 4'hF};
  endproperty
  a_lanes: assert property (p_lanes)
    else $error("wrong set of driven lines");
  property p_rej_pulse;
    @(posedge clk) disable iff (!rstn) $rose(read_rejected) |-> s_pulse;
  endproperty
  a_rej_pulse: assert property (p_rej_pulse)
    else $error("refusal flag longer than one cycle");
  property p_rej_wip;
    @(posedge clk) disable iff (!rstn)
      read_rejected |-> write_in_progress_flag;
  endproperty
  a_rej_wip: assert property (p_rej_wip)
    else $error("refusal without a write cycle");
  property p_rej_quiet;
    @(posedge clk) disable iff (!rstn)
      read_rejected |-> io_oe == 4'h0 && !read_active;
  endproperty
  a_rej_quiet: assert property (p_rej_quiet)
    else $error("refused read still drives");
  // the step is judged only between two samples inside one data phase
  property p_step;
    @(negedge sck) disable iff (!rstn || cs_n)
      io_oe != 4'h0 && $past(io_oe) != 4'h0 && $changed(mem_req.addr)
      |-> mem_req.addr == $past(mem_req.addr) + 24'h1;
  endproperty
  a_step: assert property (p_step)
    else $error("address did not step by one");
  property p_skip_qpi;
    @(posedge clk) disable iff (!rstn)
      qpi_mode_en && $past(qpi_mode_en, 3) |-> !$rose(command_skip_mode);
  endproperty
  a_skip_qpi: assert property (p_skip_qpi)
    else $error("command skip entered in four-line mode");
  property p_reset;
    @(posedge clk) $rose(rstn) |-> io_oe == 4'h0 && mem_req == '0
      && !read_active && !command_skip_mode && !read_rejected;
  endproperty
  a_reset: assert property (p_reset)
    else $error("outputs not idle after reset");
endmodule

bind dtr_read_sequencer dtr_read_sequencer_chk u_chk (.clk, .rstn, .sck,
  .cs_n, .io_oe, .mem_req, .write_in_progress_flag, .qpi_mode_en,
  .read_active, .command_skip_mode, .read_rejected);

`default_nettype wire

// ==== flash_host_model.sv ====
// host side of the link: frames of opcode, address, dummies and data
// assumes one call at a time; sck stands low between calls
`timescale 1ns/100ps
`default_nettype none

module flash_host_model
(
  // link out of the host
  output var logic       sck,
  output var logic       cs_n,
  output var logic [3:0] io_in,
  // link back from the device
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe
);
  initial
  begin
    sck = 1'b0;
    cs_n = 1'b1;
    io_in = 4'h0;
  end

  // one clock: a stands over the rise, b over the fall; a moves 1 ns
  // after the fall so that the fall still samples b
  // a line the device does not drive reads back inverted
  task automatic tick(input logic [3:0] a, b, output logic [3:0] ra, rb);
    #1 io_in = a;
    #2.7 ra = io_out ^ ~io_oe;
    #3.8 sck = 1'b1;
    #1 io_in = b;
    #2.7 rb = io_out ^ ~io_oe;
    #3.8 sck = 1'b0;
  endtask

  function automatic logic [3:0] slot(logic [23:0] v, int i, int ln);
    return 4'(v >> (i - ln)) & 4'((1 << ln) - 1);
  endfunction

  function automatic logic [3:0] lane(logic [3:0] x, int ln);
    return ln == 1 ? {3'h0, x[1]} : ln == 2 ? {2'h0, x[1:0]} : x;
  endfunction

  // n bits msb first, ln lanes a slot, two slots a clock when dtr
  task automatic tx(input logic [23:0] v, input int n, ln, input bit dtr);
    logic [3:0] a, b, ra, rb;
    int         i;
    i = n;
    while (i > 0)
    begin
      a = slot(v, i, ln);
      i = i - ln;
      b = dtr ? slot(v, i, ln) : a;
      if (dtr)
        i = i - ln;
      tick(a, b, ra, rb);
    end
  endtask

  task automatic idle(input int n);
    logic [3:0] ra, rb;
    cs_n = 1'b1;
    repeat (n) tick(4'h0, 4'h0, ra, rb);
  endtask

  task automatic frame(input bit qpi, skip, input logic [7:0] op,
    input int ln, input bit dtr, input logic [23:0] ad,
    input logic [7:0] md, input int nd,
    output logic [31:0] r, output logic [3:0] oe);
    logic [3:0] ra, rb;
    // select off the fall, so the release of the frame reset never meets a sck edge
    #1 cs_n = 1'b0;
    if (!skip)
      tx(24'(op), 8, qpi ? 4 : 1, 1'b0);
    tx(ad, 24, ln, dtr);
    tx(24'(md >> (8 - 2 * ln)), 2 * ln, ln, 1'b1);
    // released lines seen as a toggling pattern
    repeat (nd - 1) tick(4'h5, 4'hA, ra, rb);
    r = '0;
    oe = 4'h0;
    repeat (24 / (dtr ? 2 * ln : ln))
    begin
      tick(4'hA, 4'h5, ra, rb);
      oe = oe | io_oe;
      r = (r << ln) | 32'(lane(ra, ln));
      if (dtr)
        r = (r << ln) | 32'(lane(rb, ln));
    end
    cs_n = 1'b1;
  endtask
endmodule

`default_nettype wire

// ==== tb_dtr_read_sequencer.sv ====
// self-checking bench of the dtr read sequencer with a host model
// assumes the array answers mem_req combinationally
`timescale 1ns/100ps
`default_nettype none

`define CHK(g, e) \
  begin \
    n_compared++; \
    if ((g) !== (e)) \
    begin \
      n_mismatch++; \
      $display("unexpected at %0t: got %h want %h", $time, g, e); \
    end \
  end

module tb_dtr_read_sequencer
  import flash_read_pkg::*;
;
  typedef struct {
    bit          qpi;
    logic [7:0]  op;
    int          ln;
    bit          dtr;
    logic [23:0] ad;
    logic [7:0]  md;
    logic [3:0]  dc;
    int          nd;
    bit          info;
    logic [3:0]  oe;
  } row_type;

  function automatic logic [7:0] exp_byte(logic info, logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16] ^ {info, 7'h00};
  endfunction

  function automatic logic [23:0] exp3(logic info, logic [23:0] a);
    return {exp_byte(info, a), exp_byte(info, a + 24'h1),
            exp_byte(info, a + 24'h2)};
  endfunction

  logic            clk = 1'b0;
  logic            rstn = 1'b0;
  logic            write_in_progress_flag = 1'b0;
  logic            qpi_mode_en = 1'b0;
  logic [3:0]      dummy_cfg = 4'h0;
  wire logic       sck;
  wire logic       cs_n;
  wire logic [3:0] io_in;
  wire logic [3:0] io_out;
  wire logic [3:0] io_oe;
  wire mem_req_type mem_req;
  wire logic [7:0] mem_rdata = exp_byte(mem_req.info, mem_req.addr);
  wire logic       read_active;
  wire logic       command_skip_mode;
  wire logic       read_rejected;
  int              n_mismatch = 0;
  int              n_compared = 0;
  int              n_rej = 0;
  int              rj;
  int              na;
  int              n_act = 0;
  logic [31:0]     r;
  logic [3:0]      oe;
  row_type         t;
  // info reads start on row starts only
  row_type rows [6] = '{
    '{0, 8'h68, 1, 0, 24'h001000, 8'h00, 4'h0, 8, 1, 4'h2},
    '{1, 8'h68, 4, 0, 24'h003000, 8'h00, 4'h0, 6, 1, 4'hF},
    '{0, 8'h0D, 1, 1, 24'hFFFFFF, 8'h00, 4'h0, 8, 0, 4'h2},
    '{0, 8'hBD, 2, 1, 24'hABCDEF, 8'h00, 4'h0, 4, 0, 4'h3},
    '{0, 8'hBD, 2, 1, 24'h00FFFE, 8'h00, 4'h6, 6, 0, 4'h3},
    '{1, 8'h0D, 4, 1, 24'h123456, 8'hA0, 4'h0, 6, 0, 4'hF}};

  dtr_read_sequencer u_dut (.clk, .rstn, .sck, .cs_n, .io_in, .io_out,
    .io_oe, .mem_req, .mem_rdata, .write_in_progress_flag, .qpi_mode_en,
    .dummy_cfg, .read_active, .command_skip_mode, .read_rejected);

  flash_host_model u_host (.sck, .cs_n, .io_in, .io_out, .io_oe);

  always #25 clk = ~clk;

  // status flops move on the rising edge, so look on the falling one
  always @(negedge clk)
  begin
    if (read_rejected === 1'b1)
      n_rej++;
    if (read_active === 1'b1)
      n_act++;
  end

  task automatic report_and_stop;
    if (n_mismatch == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // config crosses on sck, so two idle clocks precede each frame
  task automatic run(input row_type x, input bit skip);
    @(negedge clk);
    qpi_mode_en = x.qpi;
    dummy_cfg = x.dc;
    u_host.idle(2);
    u_host.frame(x.qpi, skip, x.op, x.ln, x.dtr, x.ad, x.md, x.nd, r, oe);
    #1;
    `CHK(io_oe, 4'h0)
  endtask

  initial
  begin
    #100000;
    n_mismatch++;
    report_and_stop();
  end

  initial
  begin
    u_host.idle(3);
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    @(posedge clk);
    #1;
    `CHK({io_oe, mem_req, read_active, command_skip_mode, read_rejected}, 32'h0)
    foreach (rows[k])
    begin
      run(rows[k], 1'b0);
      `CHK(r[23:0], exp3(rows[k].info, rows[k].ad))
      `CHK(oe, rows[k].oe)
    end
    repeat (6) @(negedge clk);
    `CHK(command_skip_mode, 1'b0)
    `CHK(n_act > 0, 1'b1)
    t = rows[3];
    t.md = 8'hA5;
    run(t, 1'b0);
    repeat (6) @(negedge clk);
    `CHK(command_skip_mode, 1'b1)
    t.ad = 24'h000200;
    t.md = 8'h30;
    run(t, 1'b1);
    `CHK(r[23:0], exp3(1'b0, t.ad))
    repeat (6) @(negedge clk);
    `CHK(command_skip_mode, 1'b0)
    t.md = 8'h00;
    run(t, 1'b0);
    `CHK(r[23:0], exp3(1'b0, t.ad))
    // every read kind refused while a write cycle runs
    repeat (4) @(negedge clk);
    write_in_progress_flag = 1'b1;
    na = n_act;
    foreach (rows[k])
    begin
      rj = n_rej;
      run(rows[k], 1'b0);
      repeat (6) @(posedge clk);
      `CHK(oe, 4'h0)
      `CHK(n_rej, rj + 1)
    end
    `CHK(n_act, na)
    // an unknown opcode stays silent and raises no refusal
    @(negedge clk);
    write_in_progress_flag = 1'b0;
    t.op = 8'h03;
    rj = n_rej;
    run(t, 1'b0);
    repeat (6) @(posedge clk);
    `CHK(oe, 4'h0)
    `CHK(n_rej, rj)
    report_and_stop();
  end
endmodule

`default_nettype wire
